// >>> core/arf_formatter.sv
`timescale 1ns/100ps
`default_nettype none

module arf_formatter (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  input wire logic cmd_valid,
  input wire arf_pkg::arf_cmd_type cmd,
  input wire logic [4:0] rsp_len,
  input wire logic [9:0] accel_result,
  input wire logic internal_error,
  input wire logic self_test_active_flag,
  output logic rsp_valid,
  output arf_pkg::arf_rsp_type rsp,
  output logic irq
);

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [11:0] ctrl_reg;
  logic [3:0] status_reg;
  logic [3:0] mask_reg;
  logic [15:0] last_rsp_reg;
  logic [31:0] rdata_reg;
  logic rsp_valid_reg;
  arf_pkg::arf_rsp_type rsp_reg;
  logic irq_reg;

  logic [3:0] dev_addr;
  logic [1:0] attribute_bits;
  logic [3:0] crc_len;
  logic [3:0] stat_set;
  logic [3:0] stat_clr;
  logic addr_hit;
  logic is_global;
  logic len_ok;
  logic accept;
  logic subst;
  logic [15:0] word_next;
  logic [15:0] len_mask;
  logic [7:0] trunc8;
  logic [8:0] trunc9;

  assign dev_addr = ctrl_reg[arf_pkg::ARF_CTRL_ADDR_LSB +: 4];
  assign attribute_bits = ctrl_reg[arf_pkg::ARF_CTRL_ATTR_LSB +: 2];
  assign crc_len = ctrl_reg[arf_pkg::ARF_CTRL_CRC_LSB +: 4];

  // ****************************************************************
  // request decode
  // ****************************************************************
  // only code and address are looked at; data bits feed the check code elsewhere
  assign addr_hit = (cmd.addr == dev_addr);
  assign is_global = (cmd.addr == arf_pkg::ARF_GLOBAL_ADDR);
  assign len_ok = (rsp_len >= arf_pkg::ARF_LEN_MIN) && (rsp_len <= arf_pkg::ARF_LEN_LONG);
  // a device left at address zero answers nothing, since that is the global address
  assign accept = cmd_valid && (cmd.code == arf_pkg::ARF_CMD_READ_ACCEL)
                  && addr_hit && !is_global && len_ok;

  // ****************************************************************
  // response word build
  // ****************************************************************
  assign trunc8 = accel_result[9:2];
  assign trunc9 = accel_result[9:1];

  // bits at or above the length are padding and forced low
  always_comb begin
    len_mask = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      if (5'(i) < rsp_len) begin
        len_mask[i] = 1'b1;
      end
    end
  end

  // result placement; a truncated 8- or 9-bit result of zero is replaced by one, so code 0 stays the error code
  always_comb begin
    word_next = 16'h0000;
    subst = 1'b0;
    if (rsp_len == arf_pkg::ARF_LEN_LONG) begin
      word_next = {cmd.addr, 1'b0, internal_error, accel_result};
    end else begin
      if (rsp_len == arf_pkg::ARF_LEN_MIN) begin
        if (trunc8 == 8'h00) begin
          word_next[7:0] = arf_pkg::ARF_TRUNC_MIN8;
          subst = 1'b1;
        end else begin
          word_next[7:0] = trunc8;
        end
      end else if (rsp_len == arf_pkg::ARF_LEN_NINE) begin
        if (trunc9 == 9'h000) begin
          word_next[8:0] = arf_pkg::ARF_TRUNC_MIN9;
          subst = 1'b1;
        end else begin
          word_next[8:0] = trunc9;
        end
      end else begin
        word_next[9:0] = accel_result;
      end
      // flag bits appear only where the length reaches them
      word_next[arf_pkg::ARF_BIT_ERR] = internal_error;
      word_next[arf_pkg::ARF_BIT_ZERO] = 1'b0;
      word_next[arf_pkg::ARF_BIT_SELF_TEST] = self_test_active_flag;
      word_next[arf_pkg::ARF_BIT_ATTR0] = attribute_bits[0];
      word_next[arf_pkg::ARF_BIT_ATTR1] = attribute_bits[1];
      word_next = word_next & len_mask;
    end
  end

  // ****************************************************************
  // response output
  // ****************************************************************
  // one answer per accepted request, one cycle after the command
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp_valid_reg <= 1'b0;
      rsp_reg <= '0;
      last_rsp_reg <= 16'h0000;
    end else begin
      rsp_valid_reg <= accept;
      if (accept) begin
        rsp_reg.word <= word_next;
        rsp_reg.len <= rsp_len;
        rsp_reg.crc_len <= crc_len;
        last_rsp_reg <= word_next;
      end
    end
  end

  // ****************************************************************
  // events and interrupt
  // ****************************************************************
  always_comb begin
    stat_set = 4'h0;
    stat_set[arf_pkg::ARF_EV_ANSWERED] = accept;
    stat_set[arf_pkg::ARF_EV_MISMATCH] = cmd_valid && !addr_hit && !is_global
                                         && (cmd.code == arf_pkg::ARF_CMD_READ_ACCEL);
    stat_set[arf_pkg::ARF_EV_GLOBAL] = cmd_valid && is_global
                                       && (cmd.code == arf_pkg::ARF_CMD_READ_ACCEL);
    stat_set[arf_pkg::ARF_EV_SUBST] = accept && subst;
  end

  assign stat_clr = (bus_wr && bus_addr == arf_pkg::ARF_OFF_STATUS) ? bus_wdata[3:0] : 4'h0;

  // set beats a same-cycle write-one clear so no event is lost
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_reg <= arf_pkg::ARF_STAT_RESET;
    end else begin
      status_reg <= (status_reg & ~stat_clr) | stat_set;
    end
  end

  // registered from current status, so it trails the status bit of a new event by one cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(status_reg & mask_reg);
    end
  end

  // ****************************************************************
  // register port
  // ****************************************************************
  // writes; crc length above eight is clamped to keep the frame legal
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= arf_pkg::ARF_CTRL_RESET;
      mask_reg <= arf_pkg::ARF_MASK_RESET;
    end else if (bus_wr) begin
      if (bus_addr == arf_pkg::ARF_OFF_CTRL) begin
        ctrl_reg[7:0] <= bus_wdata[7:0];
        if (bus_wdata[11:8] > arf_pkg::ARF_CRC_LEN_MAX) begin
          ctrl_reg[11:8] <= arf_pkg::ARF_CRC_LEN_MAX;
        end else begin
          ctrl_reg[11:8] <= bus_wdata[11:8];
        end
      end else if (bus_addr == arf_pkg::ARF_OFF_MASK) begin
        mask_reg <= bus_wdata[3:0];
      end
    end
  end

  // reads answer the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 32'h0000_0000;
    end else if (bus_rd) begin
      if (bus_addr == arf_pkg::ARF_OFF_CTRL) begin
        rdata_reg <= {20'h00000, ctrl_reg};
      end else if (bus_addr == arf_pkg::ARF_OFF_STATUS) begin
        rdata_reg <= {28'h0000000, status_reg};
      end else if (bus_addr == arf_pkg::ARF_OFF_MASK) begin
        rdata_reg <= {28'h0000000, mask_reg};
      end else if (bus_addr == arf_pkg::ARF_OFF_LAST_RSP) begin
        rdata_reg <= {16'h0000, last_rsp_reg};
      end else if (bus_addr == arf_pkg::ARF_OFF_ACCEL) begin
        rdata_reg <= {22'h000000, accel_result};
      end else begin
        rdata_reg <= 32'h0000_0000;
      end
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  assign bus_rdata = rdata_reg;
  assign rsp_valid = rsp_valid_reg;
  assign rsp = rsp_reg;
  assign irq = irq_reg;

  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_answer_on_accept;
    @(posedge clk) disable iff (rst)
      accept |=> rsp_valid && rsp.len == $past(rsp_len);
  endproperty
  a_answer_on_accept: assert property (p_answer_on_accept) else $error("accepted read not answered");

  property p_no_answer_mismatch;
    @(posedge clk) disable iff (rst)
      cmd_valid && cmd.addr != dev_addr |=> !rsp_valid;
  endproperty
  a_no_answer_mismatch: assert property (p_no_answer_mismatch) else $error("answered foreign address");

  property p_no_global;
    @(posedge clk) disable iff (rst)
      cmd_valid && cmd.addr == arf_pkg::ARF_GLOBAL_ADDR |=> !rsp_valid;
  endproperty
  a_no_global: assert property (p_no_global) else $error("answered global address");

  property p_long_layout;
    @(posedge clk) disable iff (rst)
      accept && rsp_len == arf_pkg::ARF_LEN_LONG |=>
        rsp.word == {$past(cmd.addr), 1'b0, $past(internal_error), $past(accel_result)};
  endproperty
  a_long_layout: assert property (p_long_layout) else $error("long response layout wrong");

  property p_short8;
    @(posedge clk) disable iff (rst)
      accept && rsp_len == arf_pkg::ARF_LEN_MIN && accel_result[9:2] != 8'h00 |=>
        rsp.word[7:0] == $past(accel_result[9:2]);
  endproperty
  a_short8: assert property (p_short8) else $error("8-bit truncation wrong");

  property p_trunc_nonzero;
    @(posedge clk) disable iff (rst)
      rsp_valid && rsp.len < arf_pkg::ARF_LEN_FULL |-> rsp.word != 16'h0000;
  endproperty
  a_trunc_nonzero: assert property (p_trunc_nonzero) else $error("truncation gave zero");

  property p_padding;
    @(posedge clk) disable iff (rst)
      rsp_valid |-> (rsp.word & ~(16'hFFFF >> (5'h10 - rsp.len))) == 16'h0000;
  endproperty
  a_padding: assert property (p_padding) else $error("bits beyond length not padded");

  property p_err_flag;
    @(posedge clk) disable iff (rst)
      accept && rsp_len > 5'h0A |=> rsp.word[arf_pkg::ARF_BIT_ERR] == $past(internal_error);
  endproperty
  a_err_flag: assert property (p_err_flag) else $error("error flag wrong");

  property p_self_test_flag;
    @(posedge clk) disable iff (rst)
      accept && rsp_len > 5'h0C && rsp_len < arf_pkg::ARF_LEN_LONG |=>
        rsp.word[arf_pkg::ARF_BIT_SELF_TEST] == $past(self_test_active_flag);
  endproperty
  a_self_test_flag: assert property (p_self_test_flag) else $error("self-test flag wrong");

  property p_irq_follows;
    @(posedge clk) disable iff (rst)
      ##1 1'b1 |-> irq == $past(|(status_reg & mask_reg));
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("interrupt level wrong");

  c_long: cover property (@(posedge clk) disable iff (rst)
    accept && rsp_len == arf_pkg::ARF_LEN_LONG);
  c_subst: cover property (@(posedge clk) disable iff (rst) accept && subst);
  c_mismatch: cover property (@(posedge clk) disable iff (rst)
    stat_set[arf_pkg::ARF_EV_MISMATCH]);

endmodule // arf_formatter

`default_nettype wire

// >>> core/arf_pkg.sv
package arf_pkg;

  // ****************************************************************
  // frame fields and codes
  // ****************************************************************
  localparam logic [3:0] ARF_CMD_READ_ACCEL = 4'h2;
  localparam logic [3:0] ARF_GLOBAL_ADDR = 4'h0;
  localparam int ARF_ACC_W = 10;
  localparam logic [4:0] ARF_LEN_MIN = 5'h08;
  localparam logic [4:0] ARF_LEN_NINE = 5'h09;
  localparam logic [4:0] ARF_LEN_FULL = 5'h0A;
  localparam logic [4:0] ARF_LEN_LONG = 5'h10;
  localparam logic [3:0] ARF_CRC_LEN_MAX = 4'h8;
  localparam logic [7:0] ARF_TRUNC_MIN8 = 8'h01;
  localparam logic [8:0] ARF_TRUNC_MIN9 = 9'h001;
  localparam logic [9:0] ARF_ACC_MID = 10'h200;

  // ****************************************************************
  // response bit positions
  // ****************************************************************
  localparam int ARF_BIT_ERR = 10;
  localparam int ARF_BIT_ZERO = 11;
  localparam int ARF_BIT_SELF_TEST = 12;
  localparam int ARF_BIT_ATTR0 = 13;
  localparam int ARF_BIT_ATTR1 = 14;

  // ****************************************************************
  // register map, fields and reset values
  // ****************************************************************
  localparam logic [7:0] ARF_OFF_CTRL = 8'h00;
  localparam logic [7:0] ARF_OFF_STATUS = 8'h04;
  localparam logic [7:0] ARF_OFF_MASK = 8'h08;
  localparam logic [7:0] ARF_OFF_LAST_RSP = 8'h0C;
  localparam logic [7:0] ARF_OFF_ACCEL = 8'h10;
  localparam int ARF_CTRL_ADDR_LSB = 0;
  localparam int ARF_CTRL_ATTR_LSB = 4;
  localparam int ARF_CTRL_CRC_LSB = 8;
  localparam logic [11:0] ARF_CTRL_RESET = 12'h000;
  localparam int ARF_STAT_W = 4;
  localparam int ARF_EV_ANSWERED = 0;
  localparam int ARF_EV_MISMATCH = 1;
  localparam int ARF_EV_GLOBAL = 2;
  localparam int ARF_EV_SUBST = 3;
  localparam logic [3:0] ARF_STAT_RESET = 4'h0;
  localparam logic [3:0] ARF_MASK_RESET = 4'h0;

  // command frame as delivered by the bus receiver
  typedef struct packed {
    logic [7:0] data;
    logic [3:0] addr;
    logic [3:0] code;
  } arf_cmd_type;

  // response frame handed to the bus transmitter
  typedef struct packed {
    logic [15:0] word;
    logic [4:0] len;
    logic [3:0] crc_len;
  } arf_rsp_type;

endpackage

// >>> bench/arf_bus_master_model.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// bus master on the two-wire sensor bus
// ****************************************************************
module arf_bus_master_model (
  input wire logic clk,
  output logic cmd_valid,
  output arf_pkg::arf_cmd_type cmd,
  output logic [4:0] rsp_len,
  input wire logic rsp_valid,
  input wire arf_pkg::arf_rsp_type rsp
);
  int n_rsp;
  arf_pkg::arf_rsp_type last_rsp;

  // idle bus until the first frame
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
    rsp_len = 5'h10;
    n_rsp = 0;
  end

  // one frame: code, address and data fields with the length of the reply
  task automatic send(input logic [3:0] code, input logic [3:0] addr, input logic [7:0] data,
                      input logic [4:0] len);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= '{data: data, addr: addr, code: code};
    rsp_len <= len;
    @(posedge clk);
    cmd_valid <= 1'b0;
    // released fields carry junk so stale values are never mistaken for a frame
    cmd <= ~{data, addr, code};
    rsp_len <= ~len;
  endtask

  // collect every reply the device sends
  always @(posedge clk) begin
    if (rsp_valid === 1'b1) begin
      n_rsp <= n_rsp + 1;
      last_rsp <= rsp;
    end
  end
endmodule // arf_bus_master_model

`default_nettype wire

// >>> bench/arf_formatter_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module arf_formatter_tb_top;
  typedef struct packed {
    logic [9:0] acc;
    logic [4:0] len;
    logic err;
    logic self_test;
    logic [7:0] data;
    logic [15:0] exp;
  } arf_row_type;

  logic clk;
  logic rst;
  logic [7:0] bus_addr;
  logic [31:0] bus_wdata;
  logic bus_wr;
  logic bus_rd;
  logic [31:0] bus_rdata;
  logic cmd_valid;
  arf_pkg::arf_cmd_type cmd;
  logic [4:0] rsp_len;
  logic [9:0] accel_result;
  logic internal_error;
  logic self_test_active_flag;
  logic rsp_valid;
  arf_pkg::arf_rsp_type rsp;
  logic irq;
  int n_mismatch;
  int n_compared;
  int cycles;
  int base;
  logic [31:0] rd_val;
  arf_row_type rows [12];

  arf_formatter dut_u (.clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .cmd_valid(cmd_valid), .cmd(cmd),
    .rsp_len(rsp_len), .accel_result(accel_result), .internal_error(internal_error),
    .self_test_active_flag(self_test_active_flag), .rsp_valid(rsp_valid), .rsp(rsp), .irq(irq));

  arf_bus_master_model master_u (.clk(clk), .cmd_valid(cmd_valid), .cmd(cmd),
    .rsp_len(rsp_len), .rsp_valid(rsp_valid), .rsp(rsp));

  // ****************************************************************
  // clock, watchdog and shared tasks
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // whole run needs well under a thousand cycles, so this only trips on a hang
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch = n_mismatch + 1;
      test_done();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_wr <= 1'b0;
    bus_wdata <= ~d;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 d = bus_rdata;
  endtask

  task automatic frame(input logic [3:0] code, input logic [3:0] addr, input logic [7:0] data,
                       input logic [4:0] len);
    master_u.send(code, addr, data, len);
    @(posedge clk);
    #1;
  endtask

  task automatic test_done();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    rst = 1'b1;
    bus_addr = 8'h00;
    bus_wdata = 32'h0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    accel_result = 10'h200;
    internal_error = 1'b0;
    self_test_active_flag = 1'b0;
    n_mismatch = 0;
    n_compared = 0;
    cycles = 0;
    // address 5, attr0 = 1, attr1 = 0
    rows = '{'{10'h200, 5'h10, 1'b0, 1'b0, 8'h00, 16'h5200},
             '{10'h3FF, 5'h10, 1'b1, 1'b1, 8'hFF, 16'h57FF},
             '{10'h2FE, 5'h08, 1'b1, 1'b1, 8'hA5, 16'h00BF},
             '{10'h003, 5'h08, 1'b0, 1'b0, 8'h5A, 16'h0001},
             '{10'h001, 5'h09, 1'b0, 1'b0, 8'h3C, 16'h0001},
             '{10'h155, 5'h09, 1'b1, 1'b0, 8'hC3, 16'h00AA},
             '{10'h000, 5'h0A, 1'b0, 1'b1, 8'h0F, 16'h0000},
             '{10'h2AA, 5'h0B, 1'b1, 1'b1, 8'hF0, 16'h06AA},
             '{10'h2AA, 5'h0C, 1'b1, 1'b1, 8'h11, 16'h06AA},
             '{10'h2AA, 5'h0D, 1'b0, 1'b1, 8'h22, 16'h12AA},
             '{10'h2AA, 5'h0E, 1'b0, 1'b1, 8'h44, 16'h32AA},
             '{10'h2AA, 5'h0F, 1'b1, 1'b0, 8'h88, 16'h26AA}};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    #1;
    check({31'h0, rsp_valid}, 32'h0);
    check({31'h0, irq}, 32'h0);
    reg_rd(arf_pkg::ARF_OFF_CTRL, rd_val);
    check(rd_val, 32'h0);
    reg_rd(arf_pkg::ARF_OFF_STATUS, rd_val);
    check(rd_val, 32'h0);
    reg_rd(arf_pkg::ARF_OFF_MASK, rd_val);
    check(rd_val, 32'h0);
    reg_rd(8'h20, rd_val);
    check(rd_val, 32'h0);
    // check length above eight is clamped
    reg_wr(arf_pkg::ARF_OFF_CTRL, 32'h00000F15);
    reg_rd(arf_pkg::ARF_OFF_CTRL, rd_val);
    check(rd_val, 32'h00000815);
    // table of ordinary reads, data field varied to show it has no effect
    foreach (rows[i]) begin
      accel_result <= rows[i].acc;
      internal_error <= rows[i].err;
      self_test_active_flag <= rows[i].self_test;
      base = master_u.n_rsp;
      frame(arf_pkg::ARF_CMD_READ_ACCEL, 4'h5, rows[i].data, rows[i].len);
      check(master_u.n_rsp - base, 1);
      check({16'h0, master_u.last_rsp.word}, {16'h0, rows[i].exp});
      check({27'h0, master_u.last_rsp.len}, {27'h0, rows[i].len});
      check({28'h0, master_u.last_rsp.crc_len}, 32'h8);
    end
    reg_rd(arf_pkg::ARF_OFF_LAST_RSP, rd_val);
    check(rd_val, 32'h000026AA);
    reg_rd(arf_pkg::ARF_OFF_ACCEL, rd_val);
    check(rd_val, 32'h000002AA);
    // read data must fall back to zero once the answer cycle is over
    @(posedge clk);
    #1;
    check(bus_rdata, 32'h0);
    reg_rd(arf_pkg::ARF_OFF_STATUS, rd_val);
    check(rd_val, 32'h9);
    reg_wr(arf_pkg::ARF_OFF_STATUS, 32'h1);
    reg_rd(arf_pkg::ARF_OFF_STATUS, rd_val);
    check(rd_val, 32'h8);
    reg_wr(arf_pkg::ARF_OFF_STATUS, 32'hF);
    // refused frames: other code, foreign address, global address, bad length
    base = master_u.n_rsp;
    frame(4'h3, 4'h5, 8'h00, 5'h10);
    frame(4'h1, 4'h5, 8'h00, 5'h10);
    frame(arf_pkg::ARF_CMD_READ_ACCEL, 4'h6, 8'h00, 5'h10);
    frame(arf_pkg::ARF_CMD_READ_ACCEL, 4'h0, 8'h00, 5'h10);
    frame(arf_pkg::ARF_CMD_READ_ACCEL, 4'h5, 8'h00, 5'h11);
    check(master_u.n_rsp - base, 0);
    check({16'h0, rsp.word}, 32'h000026AA);
    reg_rd(arf_pkg::ARF_OFF_STATUS, rd_val);
    check(rd_val, 32'h6);
    reg_wr(arf_pkg::ARF_OFF_STATUS, 32'hF);
    // interrupt raised by an answer, masked, then cleared
    reg_wr(arf_pkg::ARF_OFF_MASK, 32'h1);
    frame(arf_pkg::ARF_CMD_READ_ACCEL, 4'h5, 8'h00, 5'h10);
    check({31'h0, irq}, 32'h1);
    reg_wr(arf_pkg::ARF_OFF_MASK, 32'h0);
    @(posedge clk);
    #1;
    check({31'h0, irq}, 32'h0);
    reg_wr(arf_pkg::ARF_OFF_STATUS, 32'h1);
    reg_wr(arf_pkg::ARF_OFF_MASK, 32'h1);
    @(posedge clk);
    #1;
    check({31'h0, irq}, 32'h0);
    // reset in mid-run returns outputs and registers to their reset values
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    check({31'h0, rsp_valid}, 32'h0);
    check({31'h0, irq}, 32'h0);
    check({16'h0, rsp.word}, 32'h0);
    reg_rd(arf_pkg::ARF_OFF_CTRL, rd_val);
    check(rd_val, 32'h0);
    // address is back at zero, which is the global address and never answered
    base = master_u.n_rsp;
    frame(arf_pkg::ARF_CMD_READ_ACCEL, 4'h0, 8'h00, 5'h10);
    check(master_u.n_rsp - base, 0);
    test_done();
  end
endmodule // arf_formatter_tb_top

`default_nettype wire
